//--- rtl/fpd_pkg.sv
// Package for the fast-page DRAM controller: timing counts and carriers
package fpd_pkg;
  localparam int CLK_NS = 10;
  // Least times in ns (wake-up in us) and their cycle counts (rounded up)
  localparam int T_WAKE_US = 200;
  localparam int T_WAKE_CYC = (T_WAKE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int T_RP_NS = 40;
  localparam int T_RP_CYC = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RAS_NS = 60;
  localparam int T_RAS_CYC = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_RCD_NS = 20;
  localparam int T_RCD_CYC = (T_RCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CAS_NS = 30;
  localparam int T_CAS_CYC = (T_CAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_CSR_NS = 10;
  localparam int T_CSR_CYC = (T_CSR_NS + CLK_NS - 1) / CLK_NS;
  // Refresh period: 8 ms over 512 rows, longest time rounds down
  localparam int T_REF_MS = 8;
  localparam int REF_ROWS = 512;
  localparam int T_REFI_CYC = (T_REF_MS * 1000000 / REF_ROWS) / CLK_NS;
  localparam int WAKE_REFS = 8;
  localparam logic [15:0] RST_DATA = 16'h0000;

  typedef struct packed {
    logic row_strobe_n;
    logic lower_column_strobe_n;
    logic upper_column_strobe_n;
    logic write_strobe_n;
    logic output_enable_n;
  } fpd_strobe_s;
endpackage

//--- rtl/fpd_ctrl.sv
// Host controller driving a 256K x 16 fast-page DRAM through its pins
`timescale 1ns/1ps
module fpd_ctrl #(
  parameter int WAKE_CYC = fpd_pkg::T_WAKE_CYC,
  parameter int REFI_CYC = fpd_pkg::T_REFI_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // User request: single early-write or read, byte lanes selectable
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [17:0] req_addr,
  input wire logic [1:0] req_bytes,
  input wire logic [15:0] req_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic init_done,
  // Memory pins
  output fpd_pkg::fpd_strobe_s mem_strobe,
  output logic [8:0] mem_addr,
  input wire logic [15:0] mem_dq_in,
  output logic [15:0] mem_dq_out,
  output logic [15:0] mem_dq_oe
);
  typedef enum logic [6:0] {
    ST_WAKE = 7'h01, ST_IDLE = 7'h02, ST_ROW = 7'h04, ST_COL = 7'h08,
    ST_PRE = 7'h10, ST_RCAS = 7'h20, ST_RRAS = 7'h40
  } fpd_state_e;

  fpd_state_e state;
  logic [15:0] cnt;
  logic [14:0] refi;
  logic [3:0] refs_left;
  logic ref_due;
  logic ref_late;
  logic is_write;
  logic [1:0] lanes;
  logic [8:0] col;
  logic [15:0] dq_s1, dq_s2;

  function automatic logic [15:0] cyc16(input int n);
    cyc16 = 16'(n - 1);
  endfunction

  // Data pins pass two flops, as the memory is asynchronous
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      dq_s1 <= fpd_pkg::RST_DATA;
      dq_s2 <= fpd_pkg::RST_DATA;
    end
    else
    begin
      dq_s1 <= mem_dq_in;
      dq_s2 <= dq_s1;
    end

  // Refresh interval timer; an overrun restarts the eight wake-up refreshes
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      refi <= '0;
      ref_due <= 1'b0;
      ref_late <= 1'b0;
    end
    else if (state == ST_RCAS)
    begin
      refi <= '0;
      ref_due <= 1'b0;
      ref_late <= 1'b0;
    end
    else if (refi == 15'(REFI_CYC - 1))
    begin
      // Keep timing while a refresh waits; a second wrap is an overrun
      refi <= '0;
      ref_due <= 1'b1;
      ref_late <= ref_due;
    end
    else
      refi <= refi + 15'h0001;

  assign req_ready = (state == ST_IDLE) && !ref_due && init_done;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      state <= ST_WAKE;
      cnt <= '0;
      refs_left <= 4'(fpd_pkg::WAKE_REFS);
      init_done <= 1'b0;
      mem_strobe <= '1;
      mem_addr <= '0;
      mem_dq_out <= '0;
      mem_dq_oe <= '0;
      rsp_valid <= 1'b0;
      rsp_rdata <= fpd_pkg::RST_DATA;
      is_write <= 1'b0;
      lanes <= '0;
      col <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state)
        ST_WAKE:
          if (cnt == cyc16(WAKE_CYC))
          begin
            cnt <= '0;
            state <= ST_PRE;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_IDLE:
          if (ref_late && init_done)
          begin
            // Overran a whole interval with no refresh: wake again
            init_done <= 1'b0;
            refs_left <= 4'(fpd_pkg::WAKE_REFS);
            state <= ST_RCAS;
            mem_strobe.lower_column_strobe_n <= 1'b0;
            mem_strobe.upper_column_strobe_n <= 1'b0;
          end
          else if (ref_due || !init_done)
          begin
            // Column-first refresh: address, write and enable don't care
            state <= ST_RCAS;
            mem_strobe.lower_column_strobe_n <= 1'b0;
            mem_strobe.upper_column_strobe_n <= 1'b0;
          end
          else if (req_valid)
          begin
            is_write <= req_write;
            lanes <= req_bytes;
            col <= req_addr[8:0];
            mem_addr <= req_addr[17:9];
            mem_strobe.row_strobe_n <= 1'b0;
            // Write strobe low before column strobe: early write
            mem_strobe.write_strobe_n <= !req_write;
            mem_strobe.output_enable_n <= req_write;
            mem_dq_out <= req_wdata;
            // Drive only lanes whose strobe will fall
            mem_dq_oe <= req_write ?
              {{8{req_bytes[1]}}, {8{req_bytes[0]}}} : '0;
            state <= ST_ROW;
          end
        ST_ROW:
          if (cnt == cyc16(fpd_pkg::T_RCD_CYC))
          begin
            cnt <= '0;
            mem_addr <= col;
            mem_strobe.lower_column_strobe_n <= !lanes[0];
            mem_strobe.upper_column_strobe_n <= !lanes[1];
            state <= ST_COL;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_COL:
          // Wait covers the column access time; sample after sync delay
          if (cnt == cyc16(fpd_pkg::T_CAS_CYC + 2))
          begin
            cnt <= '0;
            rsp_rdata <= dq_s2;
            rsp_valid <= !is_write;
            // Read keeps write strobe high until all strobes rise
            mem_strobe <= '1;
            mem_dq_oe <= '0;
            state <= ST_PRE;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_RCAS:
          if (cnt == cyc16(fpd_pkg::T_CSR_CYC))
          begin
            cnt <= '0;
            mem_strobe.row_strobe_n <= 1'b0;
            state <= ST_RRAS;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_RRAS:
          if (cnt == cyc16(fpd_pkg::T_RAS_CYC))
          begin
            cnt <= '0;
            mem_strobe <= '1;
            if (!init_done && refs_left != 4'h0)
              refs_left <= refs_left - 4'h1;
            if (!init_done && refs_left == 4'h1)
              init_done <= 1'b1;
            state <= ST_PRE;
          end
          else
            cnt <= cnt + 16'h0001;
        ST_PRE:
          // All strobes high for precharge before any new cycle
          if (cnt == cyc16(fpd_pkg::T_RP_CYC))
          begin
            cnt <= '0;
            state <= ST_IDLE;
          end
          else
            cnt <= cnt + 16'h0001;
        default:
          state <= ST_IDLE;
      endcase
    end

  a_read_pulse: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    rsp_valid |-> $past(state) == ST_COL && !$past(is_write))
    else $error("read answer outside column phase");
  a_strobe_high: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state == ST_PRE |-> mem_strobe == '1)
    else $error("strobes not high in precharge");
  a_no_early_use: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $rose(init_done) |-> refs_left == 4'h0 && state == ST_PRE)
    else $error("wake-up ended before eight refreshes");
  a_cbr_order: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $fell(mem_strobe.row_strobe_n) && state == ST_RRAS |->
      !mem_strobe.lower_column_strobe_n)
    else $error("column strobe not low before row strobe");
  a_write_early: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $fell(mem_strobe.lower_column_strobe_n) && is_write && state == ST_COL
      |-> !mem_strobe.write_strobe_n)
    else $error("write strobe late for early write");
  a_lane_oe: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    state == ST_COL |-> mem_dq_oe[7:0] == {8{is_write && lanes[0]}})
    else $error("lower lane drive mismatch");
  a_write_oe: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    mem_dq_oe != '0 |-> mem_strobe.output_enable_n)
    else $error("output enable low while driving data");
  a_cas_width: assert property (@(posedge clk_sys)
    disable iff (!rst_n)
    $fell(mem_strobe.lower_column_strobe_n) && state == ST_COL
      |-> mem_strobe.lower_column_strobe_n == 1'b0 [*3])
    else $error("column strobe pulse too short");
endmodule

//--- verif/fpd_mem_model.sv
// Behavioural fast-page memory model facing the controller
`timescale 1ns/1ps
module fpd_mem_model #(
  parameter int WAKE_CYC = 50,
  parameter int REFI_CYC = 200
) (
  // Memory pins
  input wire fpd_pkg::fpd_strobe_s mem_strobe,
  input wire logic [8:0] mem_addr,
  input wire logic [15:0] mem_dq_out,
  input wire logic [15:0] mem_dq_oe,
  output logic [15:0] mem_dq_in,
  // Observation
  output int refs,
  output int viol
);
  logic [15:0] mem [int];
  logic [8:0] row;
  logic column_first_refresh;
  logic cas_seen;
  logic ras_act;
  logic [15:0] rdv;
  logic [1:0] cas_n;
  logic [1:0] drv;
  realtime lastref;
  assign cas_n = {mem_strobe.upper_column_strobe_n,
    mem_strobe.lower_column_strobe_n};
  initial
  begin
    refs = 0;
    viol = 0;
    column_first_refresh = 0;
    cas_seen = 0;
    ras_act = 0;
    rdv = 16'h0000;
    row = 9'h000;
    lastref = 0;
  end
  // Interval is scaled; slack covers one access finishing first
  task automatic bump();
    if (refs >= 8 && $realtime - lastref > (REFI_CYC + 16) * 10.0)
      viol++;
    lastref = $realtime;
    refs++;
  endtask
  task automatic col_fall(input int l);
    if (!mem_strobe.row_strobe_n && !column_first_refresh)
    begin
      cas_seen = 1;
      if (refs < 8)
        viol++;
      if (!mem_strobe.write_strobe_n)
      begin
        if (mem_dq_oe[l*8+:8] !== 8'hff)
          viol++;
        mem[{row, mem_addr}][l*8+:8] = mem_dq_out[l*8+:8];
      end
      else
        rdv = mem.exists({row, mem_addr}) ? mem[{row, mem_addr}] : 16'h0000;
    end
  endtask
  always @(negedge mem_strobe.row_strobe_n)
  begin
    ras_act = 1;
    if ($realtime < WAKE_CYC * 10.0)
      viol++;
    column_first_refresh = (cas_n != 2'b11);
    if (column_first_refresh)
      bump();
    else
      row = mem_addr;
    cas_seen = 0;
  end
  // Only a real low pulse counts, not the first rise out of unknown
  always @(posedge mem_strobe.row_strobe_n)
  begin
    if (ras_act && !column_first_refresh && !cas_seen)
      bump();
    ras_act = 0;
  end
  always @(negedge mem_strobe.lower_column_strobe_n)
    col_fall(0);
  always @(negedge mem_strobe.upper_column_strobe_n)
    col_fall(1);
  // Only early writes are legal from this controller
  always @(negedge mem_strobe.write_strobe_n)
    if (!mem_strobe.row_strobe_n && cas_n != 2'b11 && !column_first_refresh)
      viol++;
  // Released lanes show the inverse so stale data cannot pass
  always @*
    for (int l = 0; l < 2; l++)
      drv[l] = !mem_strobe.row_strobe_n && !cas_n[l] && !column_first_refresh &&
        mem_strobe.write_strobe_n && !mem_strobe.output_enable_n;
  assign mem_dq_in[7:0] = drv[0] ? rdv[7:0] : ~rdv[7:0];
  assign mem_dq_in[15:8] = drv[1] ? rdv[15:8] : ~rdv[15:8];
endmodule

//--- verif/fpd_ctrl_tb.sv
// Self-checking bench for the fast-page memory controller
`timescale 1ns/1ps
module fpd_ctrl_tb;
  typedef struct packed {
    logic wr;
    logic [17:0] addr;
    logic [1:0] bytes;
    logic [15:0] data;
    logic [15:0] mask;
  } fpd_op_s;
  logic clk_sys = 0;
  logic rst_n = 0;
  logic req_valid = 0;
  logic req_ready;
  logic req_write = 0;
  logic [17:0] req_addr = 18'h00000;
  logic [1:0] req_bytes = 2'h3;
  logic [15:0] req_wdata = 16'h0000;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  logic init_done;
  fpd_pkg::fpd_strobe_s mem_strobe;
  logic [8:0] mem_addr;
  logic [15:0] mem_dq_in;
  logic [15:0] mem_dq_out;
  logic [15:0] mem_dq_oe;
  int refs;
  int viol;
  int error_cnt = 0;
  int n_compared = 0;
  int r0;
  fpd_op_s ops [8] = '{
    '{1'b1, 18'h00a05, 2'h3, 16'haaaa, 16'hffff},
    '{1'b0, 18'h00a05, 2'h3, 16'haaaa, 16'hffff},
    '{1'b1, 18'h00a05, 2'h1, 16'h1234, 16'hffff},
    '{1'b0, 18'h00a05, 2'h3, 16'haa34, 16'hffff},
    '{1'b1, 18'h00a05, 2'h2, 16'h5600, 16'hffff},
    '{1'b0, 18'h00a05, 2'h3, 16'h5634, 16'hffff},
    '{1'b1, 18'h3ffff, 2'h3, 16'hc3e1, 16'hffff},
    '{1'b0, 18'h3ffff, 2'h1, 16'h00e1, 16'h00ff}};
  always #5 clk_sys = ~clk_sys;
  fpd_ctrl #(.WAKE_CYC(50), .REFI_CYC(200)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_bytes(req_bytes),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .mem_strobe(mem_strobe), .mem_addr(mem_addr),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
  fpd_mem_model #(.WAKE_CYC(50), .REFI_CYC(200)) mem (.mem_strobe(mem_strobe),
    .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
    .mem_dq_in(mem_dq_in), .refs(refs), .viol(viol));
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_sig(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk("wait", 1, s);
  endtask
  // Request is held from negedge until the edge that takes it
  task automatic do_op(input fpd_op_s o);
    @(negedge clk_sys);
    req_valid = 1;
    req_write = o.wr;
    req_addr = o.addr;
    req_bytes = o.bytes;
    req_wdata = o.data;
    wait_sig(req_ready);
    @(negedge clk_sys);
    req_valid = 0;
    if (!o.wr)
    begin
      wait_sig(rsp_valid);
      chk("rdata", o.data & o.mask, rsp_rdata & o.mask);
    end
    $display("test op %h done", o.addr);
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    repeat (3) @(negedge clk_sys);
    rst_n = 1;
    wait_sig(init_done);
    chk("wake refs", 1, refs >= 8);
    foreach (ops[i])
      do_op(ops[i]);
    repeat (600) @(negedge clk_sys);
    // Reset just after a refresh so the wake-up stays inside the interval
    r0 = refs;
    wait (refs != r0);
    wait_sig(req_ready);
    chk("idle strobes", 5'h1f, mem_strobe);
    chk("idle oe", 16'h0000, mem_dq_oe);
    $display("test idle done");
    rst_n = 0;
    @(negedge clk_sys);
    chk("rst strobes", 5'h1f, mem_strobe);
    chk("rst ready", 0, {init_done, req_ready});
    r0 = refs;
    rst_n = 1;
    wait_sig(init_done);
    chk("rewake refs", 1, refs - r0 >= 8);
    do_op(ops[5]);
    chk("model viol", 0, viol);
    $display("test rewake done");
    report_and_stop();
  end
endmodule
